/* evs_mem_model.sv */
// memory bus and interrupter model for the sequencer bench.
// assumes registered req/ack on the device clock.
`timescale 1ns/1ns
`default_nettype none
module evs_mem_model
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request
   input wire logic memReq,
   input wire logic [2:0] memFc,
   input wire logic [31:0] memAddr,
   input wire logic autoMode,
   // answer
   output logic memAck,
   output logic [31:0] memRData,
   output logic iackAutovec
);
   logic [1:0] w;
   logic [1:0] dly;
   // ------------------------------------------------------------
   // answer at once, then after a wait, in turn
   // ------------------------------------------------------------
   always @(posedge mclk)
   begin
      memAck <= 1'b0;
      iackAutovec <= 1'b0;
      memRData <= memRData ^ 32'h5a5a_a5a5; // never stale between answers
      if (rst)
      begin
         w <= 2'h0;
         dly <= 2'h0;
         memRData <= 32'h0;
      end
      else if (memReq && !memAck) // answers only, never masters the table
      begin
         if (w == dly)
         begin
            memAck <= 1'b1;
            w <= 2'h0;
            dly <= dly ^ 2'h2;
            memRData <= (memFc == 3'h7) ? {24'h0, 5'h08, memAddr[3:1]} : ~memAddr;
            iackAutovec <= (memFc == 3'h7) && autoMode;
         end
         else
            w <= w + 2'h1;
      end
   end
endmodule
`default_nettype wire

/* evs_pkg.sv */
// constants for the exception vectoring sequencer: vector map, status word
// layout, bus function codes, source indices and sequencer states.
// assumes a 32-bit core with a 16-bit status word and a word-wide stack bus.
`default_nettype none
package evs_pkg;
   // ---------------------------------------------------------------
   // vector table layout
   // ---------------------------------------------------------------
   localparam int NUM_VECTORS = 256;
   localparam int TABLE_BYTES = 1024;
   localparam int NUM_CPU_VECTORS = 64;
   localparam int NUM_USER_VECTORS = 192;
   localparam int VEC_ENTRY_BYTES = 4;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;
   localparam logic [31:0] RESET_SP_ADDR = 32'h0000_0000;
   localparam logic [31:0] RESET_PC_ADDR = 32'h0000_0004;
   // vector numbers
   localparam logic [7:0] VEC_BUS_ERR = 8'h02;
   localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
   localparam logic [7:0] VEC_ILLEGAL = 8'h04;
   localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
   localparam logic [7:0] VEC_BOUND = 8'h06;
   localparam logic [7:0] VEC_COND_TRAP = 8'h07;
   localparam logic [7:0] VEC_PRIV = 8'h08;
   localparam logic [7:0] VEC_TRACE = 8'h09;
   localparam logic [7:0] VEC_LINE_A = 8'h0a;
   localparam logic [7:0] VEC_LINE_F = 8'h0b;
   localparam logic [7:0] VEC_HW_BREAK = 8'h0c;
   localparam logic [7:0] VEC_FORMAT = 8'h0e;
   localparam logic [7:0] VEC_UNINIT_INT = 8'h0f;
   localparam logic [7:0] VEC_SPURIOUS = 8'h18;
   localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
   localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
   // ---------------------------------------------------------------
   // status word fields and reset values
   // ---------------------------------------------------------------
   localparam int SR_T1 = 15;
   localparam int SR_T0 = 14;
   localparam int SR_S = 13;
   localparam int SR_MASK_LO = 8;
   localparam logic [2:0] MASK_RESET = 3'h7;
   localparam logic [15:0] SR_RESET = 16'h2700;
   // ---------------------------------------------------------------
   // bus function codes and frame
   // ---------------------------------------------------------------
   localparam logic [2:0] FC_SUP_DATA = 3'h5;
   localparam logic [2:0] FC_SUP_PROG = 3'h6;
   localparam logic [2:0] FC_CPU_SPACE = 3'h7;
   localparam logic [3:0] CPU_SPACE_IACK = 4'hf;
   localparam logic [3:0] FRAME_FMT_SHORT = 4'h0;
   localparam logic [1:0] FRAME_LAST_WORD = 2'h3;
   localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
   // ---------------------------------------------------------------
   // exception sources, index order is priority order (0 highest)
   // ---------------------------------------------------------------
   localparam int SRC_ADDR_ERR = 0;
   localparam int SRC_BUS_ERR = 1;
   localparam int SRC_BOUND = 2;
   localparam int SRC_ZERO_DIV = 3;
   localparam int SRC_COND_TRAP = 4;
   localparam int SRC_TRAP = 5;
   localparam int SRC_FORMAT = 6;
   localparam int SRC_ILLEGAL = 7;
   localparam int SRC_LINE_A = 8;
   localparam int SRC_LINE_F = 9;
   localparam int SRC_PRIV = 10;
   localparam int SRC_TRACE = 11;
   localparam int SRC_HW_BREAK = 12;
   localparam int SRC_INT = 13;
   localparam int NUM_SRC = 14;
   // sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_RST_SP = 7'b0000010,
      ST_RST_PC = 7'b0000100,
      ST_IACK = 7'b0001000,
      ST_PUSH = 7'b0010000,
      ST_VFETCH = 7'b0100000,
      ST_HALT = 7'b1000000
   } evs_state_t;
endpackage
`default_nettype wire

/* evs_prio_sel.sv */
// priority picker: selects the most urgent pending exception source and
// forms its vector number unless the source is the interrupt. purely combinational, same clock as the caller.
`timescale 1ns/1ns
`default_nettype none
module evs_prio_sel
   import evs_pkg::*;
(
   // pending sources and operands
   input wire logic [NUM_SRC-1:0] pend,
   input wire logic [3:0] trapNum,
   // selection
   output logic selValid,
   output logic [NUM_SRC-1:0] selOneHot,
   output logic [7:0] selVec
);
   // ---------------------------------------------------------------
   // first set bit wins; lower index means higher group
   // ---------------------------------------------------------------
   always_comb
   begin
      selOneHot = '0;
      selValid = 1'b0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (pend[i] && !selValid)
         begin
            selOneHot[i] = 1'b1;
            selValid = 1'b1;
         end
      end
   end

   // vector number for internally numbered sources
   always_comb
   begin
      selVec = VEC_UNINIT_INT;
      case (1'b1)
         selOneHot[SRC_ADDR_ERR]: selVec = VEC_ADDR_ERR;
         selOneHot[SRC_BUS_ERR]: selVec = VEC_BUS_ERR;
         selOneHot[SRC_BOUND]: selVec = VEC_BOUND;
         selOneHot[SRC_ZERO_DIV]: selVec = VEC_ZERO_DIV;
         selOneHot[SRC_COND_TRAP]: selVec = VEC_COND_TRAP;
         selOneHot[SRC_TRAP]: selVec = VEC_TRAP_BASE + {4'h0, trapNum};
         selOneHot[SRC_FORMAT]: selVec = VEC_FORMAT;
         selOneHot[SRC_ILLEGAL]: selVec = VEC_ILLEGAL;
         selOneHot[SRC_LINE_A]: selVec = VEC_LINE_A;
         selOneHot[SRC_LINE_F]: selVec = VEC_LINE_F;
         selOneHot[SRC_PRIV]: selVec = VEC_PRIV;
         selOneHot[SRC_TRACE]: selVec = VEC_TRACE;
         selOneHot[SRC_HW_BREAK]: selVec = VEC_HW_BREAK;
         default: selVec = VEC_UNINIT_INT; // interrupts get theirs by acknowledge
      endcase
   end
endmodule
`default_nettype wire

/* evs_sequencer.sv */
// exception entry sequencer: pending latches, reset vector fetch, interrupt
// acknowledge, frame push and relocatable vector fetch.
// assumes a same-clock memory bus with req/ack handshake; interrupt level pins
// are asynchronous and pass a two-flop synchroniser.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [RL1] table is 256 vectors, 1024 bytes at base
// [RL2] vectors 0-63 processor, 64-255 user interrupts
// [RL3] entries one long word; reset entry two
// [RL4] reset loads stack pointer, then program counter
// [RL5] vectors 2-15 fixed to internal exception causes
// [RL6] spurious is 24, autovectors 25-31 levels 1-7
// [RL7] vector call operand n selects 32+n
// [RL8] fetches in supervisor data, reset in program
// [RL9] vector address is base plus number times four
// [RL10] only reset vector fixed; others base-relative
// [RL11] interrupts acknowledge in cpu space, others internal
// [RL12] interrupter returns vector unless autovectored
// [RL13] copy status, set supervisor, clear trace, mask
// [RL14] push status, counter, vector offset, format
// [RL15] format zero always accepted, four words
// [RL16] load vector into counter; resume if none pending
// [RL17] illegal, privilege, odd fetch, odd operand raise
// [RL18] accept interrupt, breakpoint, bus error, reset
// [RL19] simultaneous exceptions taken group 0 to 4
// [RL20] other masters should not touch cpu vectors
// [RL21] reset sets priority mask to seven
// [RL22] reset clears vector base to zero
module evs_sequencer
   import evs_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // software access to base and status word
   input wire logic vbrWrEn,
   input wire logic [31:0] vbrWrData,
   input wire logic srWrEn,
   input wire logic [15:0] srWrData,
   input wire logic [31:0] curPc,
   // internal exception causes, one-cycle pulses
   input wire logic illegalInstr,
   input wire logic privViolation,
   input wire logic lineAInstr,
   input wire logic lineFInstr,
   input wire logic zeroDivide,
   input wire logic boundCheck,
   input wire logic condTrap,
   input wire logic trapCall,
   input wire logic [3:0] trapOperand,
   input wire logic fetchStrobe,
   input wire logic fetchAddrLsb,
   input wire logic operandStrobe,
   input wire logic operandAddrLsb,
   input wire logic operandByte,
   input wire logic rteCheck,
   input wire logic [3:0] rteFormat,
   input wire logic traceReq,
   // external exception causes
   input wire logic hwBreakReq,
   input wire logic busErrReq,
   input wire logic [2:0] intLevelPin,
   // memory bus
   input wire logic memAck,
   input wire logic memBusErr,
   input wire logic [31:0] memRData,
   input wire logic iackAutovec,
   output logic memReq,
   output logic memWrite,
   output logic memLong,
   output logic [2:0] memFc,
   output logic [31:0] memAddr,
   output logic [15:0] memWData,
   // results
   output logic pcLoad,
   output logic [31:0] newPc,
   output logic resumeOk,
   output logic [15:0] statusWord,
   output logic [31:0] vectorBaseReg,
   output logic [31:0] stackPtr,
   output logic [7:0] vecNum,
   output logic inException,
   output logic halted
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   evs_state_t state_q, state_d;
   logic [15:0] sr_q, sr_d, savedSr_q, savedSr_d;
   logic [31:0] vbr_q, vbr_d, ssp_q, ssp_d, savedPc_q, savedPc_d, newPc_q, newPc_d;
   logic [31:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [7:0] vec_q, vec_d;
   logic [1:0] word_q, word_d;
   logic [2:0] fc_q, fc_d, intLvl_q, intLvl_d;
   logic req_q, req_d, wr_q, wr_d, long_q, long_d, pcLoad_q, pcLoad_d, resume_q, resume_d;
   logic [2:0] lvlMeta_q, lvlSync_q, lvlPrev_q;
   logic [3:0] trapNum_q, trapNum_d;
   logic [NUM_SRC-2:0] pend_q, pend_d, setReq;
   logic [NUM_SRC-1:0] pendAll, selOneHot, clrSel;
   logic selValid, intPend, nmiEdge;
   logic [7:0] selVec;
   logic [31:0] vecAddr;

   // ---------------------------------------------------------------
   // interrupt level synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lvlMeta_q <= 3'h0;
         lvlSync_q <= 3'h0;
         lvlPrev_q <= 3'h0;
      end
      else
      begin
         lvlMeta_q <= intLevelPin;
         lvlSync_q <= lvlMeta_q;
         lvlPrev_q <= lvlSync_q;
      end
   end

   // level 7 ignores the mask, so take it on its rising edge only
   assign nmiEdge = (lvlSync_q == 3'h7) && (lvlPrev_q != 3'h7);
   assign intPend = (lvlSync_q > sr_q[SR_MASK_LO +: 3]) || nmiEdge; // see [RL18]

   // ---------------------------------------------------------------
   // pending latches, set beats clear in the same cycle
   // ---------------------------------------------------------------
   always_comb
   begin
      setReq = '0;
      setReq[SRC_ADDR_ERR] = (fetchStrobe && fetchAddrLsb)
         || (operandStrobe && operandAddrLsb && !operandByte); // see [RL17]
      setReq[SRC_BUS_ERR] = busErrReq; // see [RL18]
      setReq[SRC_BOUND] = boundCheck;
      setReq[SRC_ZERO_DIV] = zeroDivide;
      setReq[SRC_COND_TRAP] = condTrap;
      setReq[SRC_TRAP] = trapCall;
      setReq[SRC_FORMAT] = rteCheck && (rteFormat != FRAME_FMT_SHORT); // see [RL15]
      setReq[SRC_ILLEGAL] = illegalInstr; // see [RL17]
      setReq[SRC_LINE_A] = lineAInstr;
      setReq[SRC_LINE_F] = lineFInstr;
      setReq[SRC_PRIV] = privViolation; // see [RL17]
      setReq[SRC_TRACE] = traceReq;
      setReq[SRC_HW_BREAK] = hwBreakReq; // see [RL18]
      trapNum_d = trapCall ? trapOperand : trapNum_q;
   end

   generate
      for (genvar i = 0; i < NUM_SRC - 1; i++)
      begin : g_pend
         always_comb
         begin
            pend_d[i] = setReq[i] || (pend_q[i] && !clrSel[i]);
         end
      end
   endgenerate

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pend_q <= '0; // reset drops every other exception
         trapNum_q <= 4'h0;
      end
      else
      begin
         pend_q <= pend_d;
         trapNum_q <= trapNum_d;
      end
   end

   assign pendAll = {intPend, pend_q};

   // priority choice among everything pending
   evs_prio_sel u_prio (
      .pend(pendAll),
      .trapNum(trapNum_q),
      .selValid(selValid),
      .selOneHot(selOneHot),
      .selVec(selVec)
   ); // see [RL19]

   // base-relative vector address, only reset is fixed
   assign vecAddr = vbr_q + {22'h0, vec_q, 2'b00}; // see [RL9] see [RL10] see [RL1]

   // ---------------------------------------------------------------
   // sequencer next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      sr_d = sr_q;
      savedSr_d = savedSr_q;
      vbr_d = vbrWrEn ? vbrWrData : vbr_q;
      ssp_d = ssp_q;
      savedPc_d = savedPc_q;
      newPc_d = newPc_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      vec_d = vec_q;
      word_d = word_q;
      fc_d = fc_q;
      intLvl_d = intLvl_q;
      req_d = req_q;
      wr_d = wr_q;
      long_d = long_q;
      pcLoad_d = 1'b0;
      resume_d = 1'b0;
      clrSel = '0;
      case (state_q)
         ST_IDLE:
         begin
            if (srWrEn)
               sr_d = srWrData;
            if (selValid)
            begin
               clrSel = selOneHot;
               savedSr_d = sr_q; // see [RL13]
               sr_d[SR_S] = 1'b1;
               sr_d[SR_T1] = 1'b0;
               sr_d[SR_T0] = 1'b0;
               savedPc_d = curPc;
               word_d = 2'h0;
               if (selOneHot[SRC_INT])
               begin
                  intLvl_d = lvlSync_q;
                  sr_d[SR_MASK_LO +: 3] = lvlSync_q;
                  state_d = ST_IACK;
               end
               else
               begin
                  vec_d = selVec; // see [RL5] see [RL7] see [RL11]
                  state_d = ST_PUSH;
               end
            end
         end
         ST_RST_SP, ST_RST_PC, ST_IACK, ST_PUSH, ST_VFETCH:
         begin
            if (!req_q)
            begin
               // issue phase: set up the access for this state
               req_d = 1'b1;
               wr_d = (state_q == ST_PUSH);
               long_d = (state_q != ST_PUSH) && (state_q != ST_IACK);
               case (state_q)
                  ST_RST_SP:
                  begin
                     addr_d = RESET_SP_ADDR; // see [RL4] see [RL3]
                     fc_d = FC_SUP_PROG; // see [RL8]
                  end
                  ST_RST_PC:
                  begin
                     addr_d = RESET_PC_ADDR;
                     fc_d = FC_SUP_PROG;
                  end
                  ST_IACK:
                  begin
                     addr_d = {12'h000, CPU_SPACE_IACK, 12'hfff, intLvl_q, 1'b1}; // see [RL11]
                     fc_d = FC_CPU_SPACE;
                  end
                  ST_PUSH:
                  begin
                     addr_d = ssp_q - {29'h0, word_q, 1'b0} - 32'h0000_0002;
                     fc_d = FC_SUP_DATA;
                     case (word_q) // see [RL14] see [RL15]
                        2'h0: wdata_d = {FRAME_FMT_SHORT, 2'b00, vec_q, 2'b00};
                        2'h1: wdata_d = savedPc_q[15:0];
                        2'h2: wdata_d = savedPc_q[31:16];
                        default: wdata_d = savedSr_q;
                     endcase
                  end
                  default:
                  begin
                     addr_d = vecAddr; // see [RL9]
                     fc_d = FC_SUP_DATA; // see [RL8]
                  end
               endcase
            end
            else if (memBusErr)
            begin
               req_d = 1'b0;
               if (state_q == ST_IACK)
               begin
                  vec_d = VEC_SPURIOUS; // see [RL6]
                  state_d = ST_PUSH;
               end
               else
                  state_d = ST_HALT; // fault while entering: give up
            end
            else if (memAck)
            begin
               req_d = 1'b0;
               case (state_q)
                  ST_RST_SP:
                  begin
                     ssp_d = memRData;
                     state_d = ST_RST_PC;
                  end
                  ST_RST_PC:
                  begin
                     newPc_d = memRData;
                     pcLoad_d = 1'b1;
                     resume_d = 1'b1;
                     state_d = ST_IDLE;
                  end
                  ST_IACK:
                  begin
                     // see [RL12] see [RL6] see [RL2]
                     vec_d = iackAutovec ? (VEC_AUTO_BASE + {5'h00, intLvl_q}) : memRData[7:0];
                     state_d = ST_PUSH;
                  end
                  ST_PUSH:
                  begin
                     word_d = word_q + 2'h1;
                     if (word_q == FRAME_LAST_WORD)
                     begin
                        ssp_d = ssp_q - FRAME_BYTES;
                        state_d = ST_VFETCH;
                     end
                  end
                  default:
                  begin
                     newPc_d = memRData; // see [RL16]
                     pcLoad_d = 1'b1;
                     resume_d = !selValid; // see [RL16]
                     state_d = ST_IDLE;
                  end
               endcase
            end
         end
         ST_HALT:
            req_d = 1'b0; // only reset leaves this state
         default:
            state_d = ST_HALT;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_q <= ST_RST_SP;
         sr_q <= SR_RESET; // see [RL21]
         savedSr_q <= 16'h0000;
         vbr_q <= VBR_RESET; // see [RL22]
         ssp_q <= 32'h0000_0000;
         savedPc_q <= 32'h0000_0000;
         newPc_q <= 32'h0000_0000;
         addr_q <= 32'h0000_0000;
         wdata_q <= 16'h0000;
         vec_q <= 8'h00;
         word_q <= 2'h0;
         fc_q <= 3'h0;
         intLvl_q <= 3'h0;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         long_q <= 1'b0;
         pcLoad_q <= 1'b0;
         resume_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         sr_q <= sr_d;
         savedSr_q <= savedSr_d;
         vbr_q <= vbr_d;
         ssp_q <= ssp_d;
         savedPc_q <= savedPc_d;
         newPc_q <= newPc_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         vec_q <= vec_d;
         word_q <= word_d;
         fc_q <= fc_d;
         intLvl_q <= intLvl_d;
         req_q <= req_d;
         wr_q <= wr_d;
         long_q <= long_d;
         pcLoad_q <= pcLoad_d;
         resume_q <= resume_d;
      end
   end

   // outputs straight from flops (state bits are flops too)
   assign memReq = req_q;
   assign memWrite = wr_q;
   assign memLong = long_q;
   assign memFc = fc_q;
   assign memAddr = addr_q;
   assign memWData = wdata_q;
   assign pcLoad = pcLoad_q;
   assign newPc = newPc_q;
   assign resumeOk = resume_q;
   assign statusWord = sr_q;
   assign vectorBaseReg = vbr_q;
   assign stackPtr = ssp_q;
   assign vecNum = vec_q;
   assign inException = !state_q[0];
   assign halted = state_q[6];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence entryStart;
      (state_q == ST_IDLE) && selValid;
   endsequence
   sequence fetchIssue;
      (state_q == ST_VFETCH) && req_q && !$past(req_q);
   endsequence

   vec_addr_a: assert property (fetchIssue |-> memAddr == vbr_q + {22'h0, vec_q, 2'b00} && memFc == FC_SUP_DATA) // see [RL9]
      else $error("vector fetch address or space wrong");
   entry_sr_a: assert property (entryStart |=> sr_q[SR_S] && !sr_q[SR_T1] && !sr_q[SR_T0]
      && savedSr_q == $past(sr_q)) // see [RL13]
      else $error("status word not switched on entry");
   frame_fmt_a: assert property ((state_q == ST_PUSH) && req_q && word_q == 2'h0
      |-> memWData == {FRAME_FMT_SHORT, 2'b00, vec_q, 2'b00}) // see [RL14]
      else $error("frame format word wrong");
   iack_space_a: assert property ((state_q == ST_IACK) && req_q |-> memFc == FC_CPU_SPACE && !memWrite) // see [RL11]
      else $error("acknowledge not in cpu space");
   rst_fetch_a: assert property ($fell(rst) |-> ##1 memReq && memAddr == RESET_SP_ADDR && memFc == FC_SUP_PROG) // see [RL4]
      else $error("reset stack pointer fetch missing");
   rst_vals_a: assert property ($fell(rst) |-> vbr_q == VBR_RESET && sr_q[SR_MASK_LO +: 3] == MASK_RESET) // see [RL21]
      else $error("reset values wrong");
   pc_load_a: assert property (pcLoad |-> newPc == $past(memRData) && $past(memAck)) // see [RL16]
      else $error("counter not loaded from vector");
   trap_vec_a: assert property (entryStart and (selOneHot[SRC_TRAP]) |=> vec_q == VEC_TRAP_BASE + {4'h0, $past(trapNum_q)}) // see [RL7]
      else $error("vector call number wrong");
   odd_fetch_a: assert property (fetchStrobe && fetchAddrLsb |=> pend_q[SRC_ADDR_ERR] || state_q == ST_PUSH) // see [RL17]
      else $error("odd fetch not raised");
   prio_a: assert property (entryStart and (pend_q[SRC_ADDR_ERR]) |=> vec_q == VEC_ADDR_ERR) // see [RL19]
      else $error("highest group not taken first");
endmodule
`default_nettype wire

/* exception_vectoring_sequencer_tb_top.sv */
// bench for the vectoring sequencer: reset fetch, causes, interrupts.
// assumes evs_mem_model answers the bus.
`timescale 1ns/1ns
`default_nettype none
module exception_vectoring_sequencer_tb_top;
   import evs_pkg::*;
   logic mclk = '0, rst = 1'b1, vbrWrEn = '0, srWrEn = '0, autoMode = '0;
   logic memAck, iackAutovec, memReq, memWrite, pcLoad, resumeOk;
   logic [13:0] cs = '0;
   logic [3:0] trapOperand = '0, rteFormat = '0;
   logic [2:0] intLevelPin = '0, memFc;
   logic [15:0] srWrData = '0, memWData, statusWord;
   logic [31:0] vbrWrData = '0, curPc = '0, seed = 32'haf747abd, memRData, memAddr, newPc, vectorBaseReg;
   logic [7:0] vecNum;
   logic [31:0] stackPtr, sp = '1;
   logic [35:0] acc[$];
   logic [15:0] wq[$];
   int err_total = 0, checks_done = 0, n;
   int ev[14] = '{4, 8, 10, 11, 5, 6, 7, 32, 9, 12, 2, 3, 3, 14};
   evs_sequencer evs_sequencer_inst (.mclk(mclk), .rst(rst), .vbrWrEn(vbrWrEn), .vbrWrData(vbrWrData),
      .srWrEn(srWrEn), .srWrData(srWrData), .curPc(curPc), .illegalInstr(cs[0]), .privViolation(cs[1]),
      .lineAInstr(cs[2]), .lineFInstr(cs[3]), .zeroDivide(cs[4]), .boundCheck(cs[5]), .condTrap(cs[6]),
      .trapCall(cs[7]), .trapOperand(trapOperand), .traceReq(cs[8]), .hwBreakReq(cs[9]), .busErrReq(cs[10]),
      .fetchStrobe(cs[11]), .fetchAddrLsb(cs[11]), .operandStrobe(cs[12]), .operandAddrLsb(cs[12]),
      .operandByte(1'b0), .rteCheck(cs[13]), .rteFormat(rteFormat), .intLevelPin(intLevelPin),
      .memAck(memAck), .memBusErr(1'b0), .memRData(memRData), .iackAutovec(iackAutovec), .memReq(memReq),
      .memWrite(memWrite), .memLong(), .memFc(memFc), .memAddr(memAddr), .memWData(memWData),
      .pcLoad(pcLoad), .newPc(newPc), .resumeOk(resumeOk), .statusWord(statusWord),
      .vectorBaseReg(vectorBaseReg), .stackPtr(stackPtr), .vecNum(vecNum), .inException(), .halted());
   evs_mem_model evs_mem_model_inst (.mclk(mclk), .rst(rst), .memReq(memReq), .memFc(memFc),
      .memAddr(memAddr), .autoMode(autoMode), .memAck(memAck), .memRData(memRData), .iackAutovec(iackAutovec));
   always #25 mclk = ~mclk;
   // log every finished access as {fc, write, address}
   always @(posedge mclk)
   begin
      if (memReq && memAck)
      begin
         acc.push_back({memFc, memWrite, memAddr});
         if (memWrite)
            wq.push_back(memWData);
      end
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   function logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait on pcLoad or on a count of accesses
   task hold(input int k);
      n = 0;
      while ((k == 0 ? pcLoad !== 1'b1 : acc.size() < k) && n < 400)
      begin
         @(negedge mclk);
         n++;
      end
      if (n == 400)
      begin
         err_total++;
         stop_test;
      end
   endtask
   task pulse(input logic [13:0] m);
      @(posedge mclk);
      seed = lf(seed);
      cs <= m;
      trapOperand <= seed[3:0];
      rteFormat <= seed[7:4] | 4'h1;
      curPc <= seed;
      @(posedge mclk);
      cs <= '0;
   endtask
   // one entry: frame, vector fetch, counter load
   task run(input int v, input logic ok, input logic iack);
      logic [35:0] f;
      @(negedge mclk);
      hold(0);
      f = acc[$];
      sp = sp - 32'h8;
      chk("fetch", f[31:0], 32'(vbrWrData + v * 4));
      chk("space", f[35:33], FC_SUP_DATA);
      chk("offset", wq[0], {4'h0, 12'(v * 4)});
      chk("words", wq.size(), 4);
      chk("frame", {wq[3], wq[2], wq[1]}, {iack ? 16'h2000 : 16'h2700, curPc});
      chk("sp", stackPtr, sp);
      chk("newpc", newPc, 32'(~f[31:0]));
      chk("resume", resumeOk, ok);
      chk("vecnum", vecNum, v);
      chk("mode", statusWord[15:13], 3'h1);
      if (iack)
         chk("iack", acc[0][35:33], FC_CPU_SPACE);
      acc.delete();
      wq.delete();
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      hold(2);
      chk("rstsp", acc[0], {FC_SUP_PROG, 1'b0, 32'h0});
      chk("rstpc", acc[1], {FC_SUP_PROG, 1'b0, 32'h4});
      chk("sr", statusWord, 16'h2700);
      chk("vbr", vectorBaseReg, 32'h0);
      repeat (6) @(posedge mclk);
      acc.delete();
      seed = lf(seed);
      vbrWrEn <= 1'b1;
      vbrWrData <= seed;
      @(posedge mclk);
      vbrWrEn <= 1'b0;
      // every cause alone; trap operand n lands on 32 + n
      for (int i = 0; i < 14; i++)
      begin
         pulse(14'h1 << i);
         run(ev[i] + (i == 7 ? int'(seed[3:0]) : 0), 1'b1, 1'b0);
      end
      // zero divide outranks illegal when both arrive together
      pulse(14'h0011);
      run(5, 1'b0, 1'b0);
      run(4, 1'b1, 1'b0);
      for (int j = 0; j < 2; j++)
      begin
         @(posedge mclk);
         intLevelPin <= 3'h0;
         repeat (5) @(posedge mclk);
         srWrEn <= 1'b1;
         srWrData <= 16'h2000;
         autoMode <= (j == 0);
         @(posedge mclk);
         srWrEn <= 1'b0;
         intLevelPin <= 3'h3 + 3'(2 * j);
         run(j == 0 ? 27 : 8'h45, 1'b1, 1'b1);
         chk("mask", statusWord[10:8], 3'h3 + 3'(2 * j));
      end
      stop_test;
   end
endmodule
`default_nettype wire
